// [rtl/pbmc_top.sv]
`timescale 1ns/1ps
module pbmc_top (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    input  wire logic [4:0]  phy_addr_strap,
    input  wire logic        strap_an_enable,
    input  wire logic        strap_full_duplex,
    input  wire logic        power_down_input_pin_n,
    input  wire logic        mac_tx_en,
    input  wire logic        an_restart_ack,
    output logic             soft_reset_active,
    output logic             loopback_en,
    output logic [1:0]       speed_sel,
    output logic             full_duplex,
    output logic             an_enable,
    output logic             an_restart_req,
    output logic             power_down,
    output logic             isolate_en,
    output logic             mac_col
);

    logic                                pd_s1;
    logic                                pd_s2;
    logic                                tx_s1;
    logic                                tx_s2;
    logic [6:0]                          strap_s1;
    logic [6:0]                          strap_s2;
    logic [2:0]                          strap_dly;
    logic [4:0]                          phy_addr;
    logic                                sreset_busy;
    logic [pbmc_pkg::SRESET_CNT_W-1:0]   sreset_cnt;
    pbmc_pkg::pbmc_ctrl_s                ctrl;
    pbmc_pkg::pbmc_mgmt_wr_s             wr_req;
    logic [4:0]                          rd_addr;
    logic [15:0]                         rd_data;
    logic                                strap_load;
    logic                                sreset_end;
    logic                                wr_hit;
    logic                                pd_pin_asserted;
    logic [15:0]                         wd;

    // management path is never gated by power down or isolate
    pbmc_mdio_slave u_mdio (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .mdc      (mdc),
        .mdio_in  (mdio_in),
        .phy_addr (phy_addr),
        .rd_data  (rd_data),
        .mdio_out (mdio_out),
        .mdio_oe  (mdio_oe),
        .rd_addr  (rd_addr),
        .wr_req   (wr_req)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_s1    <= 1'b1;
            pd_s2    <= 1'b1;
            tx_s1    <= 1'b0;
            tx_s2    <= 1'b0;
            strap_s1 <= 7'h00;
            strap_s2 <= 7'h00;
        end else begin
            pd_s1    <= power_down_input_pin_n;
            pd_s2    <= pd_s1;
            tx_s1    <= mac_tx_en;
            tx_s2    <= tx_s1;
            strap_s1 <= {strap_full_duplex, strap_an_enable, phy_addr_strap};
            strap_s2 <= strap_s1;
        end
    end

    assign pd_pin_asserted = ~pd_s2;
    // straps are caught only once the synchroniser holds a settled value
    assign strap_load      = (strap_dly == pbmc_pkg::STRAP_READY);
    assign sreset_end      = sreset_busy && (sreset_cnt == 1);
    assign wr_hit          = wr_req.valid && (wr_req.addr == pbmc_pkg::REG_BASIC_MODE_CONTROL) && !sreset_busy;
    assign wd              = wr_req.data;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_dly <= 3'h0;
            phy_addr  <= 5'h00;
        end else if (sreset_end) begin
            strap_dly <= 3'h0;
        end else begin
            strap_dly <= {strap_dly[1:0], 1'b1};
            if (strap_load) begin
                phy_addr <= strap_s2[4:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sreset_busy <= 1'b0;
            sreset_cnt  <= '0;
        end else if (!sreset_busy) begin
            if (wr_hit && wd[pbmc_pkg::BIT_SOFT_RESET]) begin
                sreset_busy <= 1'b1;
                sreset_cnt  <= pbmc_pkg::SRESET_CNT_W'(pbmc_pkg::SRESET_CYCLES);
            end
        end else if (sreset_cnt != 0) begin
            sreset_cnt <= sreset_cnt - 1'b1;
        end else if (strap_load) begin
            sreset_busy <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= pbmc_pkg::CTRL_RESET;
        end else if (sreset_end) begin
            ctrl <= pbmc_pkg::CTRL_RESET;
        end else begin
            if (an_restart_ack) begin
                ctrl.an_restart <= 1'b0;
            end
            if (strap_load) begin
                ctrl.an_enable   <= strap_s2[5];
                ctrl.full_duplex <= strap_s2[6];
            end else if (wr_hit) begin
                ctrl.loopback    <= wd[pbmc_pkg::BIT_LOOPBACK];
                ctrl.an_enable   <= wd[pbmc_pkg::BIT_AN_ENABLE];
                ctrl.power_down  <= wd[pbmc_pkg::BIT_POWER_DOWN];
                ctrl.isolate     <= wd[pbmc_pkg::BIT_ISOLATE];
                ctrl.full_duplex <= wd[pbmc_pkg::BIT_FULL_DUPLEX];
                ctrl.col_test    <= wd[pbmc_pkg::BIT_COL_TEST];
                if ({wd[pbmc_pkg::BIT_SPEED_MSB], wd[pbmc_pkg::BIT_SPEED_LSB]} != pbmc_pkg::SPEED_RSVD) begin
                    ctrl.speed_msb <= wd[pbmc_pkg::BIT_SPEED_MSB];
                    ctrl.speed_lsb <= wd[pbmc_pkg::BIT_SPEED_LSB];
                end
                // a written 0 never clears a pending restart; set wins over the ack
                if (wd[pbmc_pkg::BIT_AN_RESTART] && wd[pbmc_pkg::BIT_AN_ENABLE]) begin
                    ctrl.an_restart <= 1'b1;
                end
            end
            if (pd_pin_asserted) begin
                ctrl.power_down <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_data = pbmc_pkg::UNMAPPED_READ;
        if (rd_addr == pbmc_pkg::REG_BASIC_MODE_CONTROL) begin
            rd_data = {sreset_busy, ctrl.loopback, ctrl.speed_lsb, ctrl.an_enable, ctrl.power_down,
                       ctrl.isolate, ctrl.an_restart, ctrl.full_duplex, ctrl.col_test, ctrl.speed_msb,
                       pbmc_pkg::RESERVED_READ};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_active <= 1'b0;
            loopback_en       <= 1'b0;
            speed_sel         <= pbmc_pkg::SPEED_1000;
            full_duplex       <= 1'b0;
            an_enable         <= 1'b0;
            an_restart_req    <= 1'b0;
            power_down        <= 1'b0;
            isolate_en        <= 1'b0;
        end else begin
            soft_reset_active <= sreset_busy;
            loopback_en       <= ctrl.loopback;
            an_enable         <= ctrl.an_enable;
            an_restart_req    <= ctrl.an_restart;
            power_down        <= ctrl.power_down | pd_pin_asserted;
            isolate_en        <= ctrl.isolate;
            // while negotiating, the manual bits are ignored and the last forced mode is held
            if (!ctrl.an_enable) begin
                speed_sel   <= {ctrl.speed_msb, ctrl.speed_lsb};
                full_duplex <= ctrl.full_duplex;
            end
        end
    end

    // three core cycles of latency meet both bit-time limits at 10 Mbps; at 100 Mbps they exceed the 4-bit-time off limit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mac_col <= 1'b0;
        end else begin
            mac_col <= ctrl.col_test & tx_s2;
        end
    end

endmodule

// [rtl/pbmc_pkg.sv]
package pbmc_pkg;

    localparam int CLK_PERIOD_NS         = 100;
    localparam int SRESET_TIME_NS        = 1000;
    localparam int SRESET_CYCLES         = (SRESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SRESET_CNT_W          = $clog2(SRESET_CYCLES + 1);
    localparam int COL_ON_BIT_TIMES      = 512;
    localparam int COL_OFF_BIT_TIMES     = 4;
    localparam int LOOPBACK_DEAD_TIME_US = 500;

    localparam logic [4:0] REG_BASIC_MODE_CONTROL = 5'h00;

    localparam int BIT_SOFT_RESET  = 15;
    localparam int BIT_LOOPBACK    = 14;
    localparam int BIT_SPEED_LSB   = 13;
    localparam int BIT_AN_ENABLE   = 12;
    localparam int BIT_POWER_DOWN  = 11;
    localparam int BIT_ISOLATE     = 10;
    localparam int BIT_AN_RESTART  = 9;
    localparam int BIT_FULL_DUPLEX = 8;
    localparam int BIT_COL_TEST    = 7;
    localparam int BIT_SPEED_MSB   = 6;

    localparam logic [5:0]  RESERVED_READ     = 6'h00;
    localparam logic [15:0] BMC_RESET_VALUE   = 16'h0040;
    localparam logic [15:0] UNMAPPED_READ     = 16'h0000;

    localparam logic [1:0] SPEED_10   = 2'h0;
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;
    localparam logic [1:0] SPEED_RSVD = 2'h3;

    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    localparam logic [2:0] STRAP_READY = 3'h3;

    typedef enum logic [2:0] {
        FR_IDLE  = 3'b000,
        FR_START = 3'b001,
        FR_OP    = 3'b010,
        FR_PHY   = 3'b011,
        FR_REG   = 3'b100,
        FR_TA    = 3'b101,
        FR_DATA  = 3'b110
    } pbmc_frame_e;

    typedef struct packed {
        logic        valid;
        logic [4:0]  addr;
        logic [15:0] data;
    } pbmc_mgmt_wr_s;

    typedef struct packed {
        logic loopback;
        logic speed_lsb;
        logic an_enable;
        logic power_down;
        logic isolate;
        logic an_restart;
        logic full_duplex;
        logic col_test;
        logic speed_msb;
    } pbmc_ctrl_s;

    localparam pbmc_ctrl_s CTRL_RESET = '{speed_msb: 1'b1, default: 1'b0};

endpackage

// [rtl/pbmc_mdio_slave.sv]
`timescale 1ns/1ps
module pbmc_mdio_slave (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic                    mdc,
    input  wire logic                    mdio_in,
    input  wire logic [4:0]              phy_addr,
    input  wire logic [15:0]             rd_data,
    output logic                         mdio_out,
    output logic                         mdio_oe,
    output logic [4:0]                   rd_addr,
    output pbmc_pkg::pbmc_mgmt_wr_s      wr_req
);

    logic                  mdc_s1;
    logic                  mdc_s2;
    logic                  mdc_s3;
    logic                  mdio_s1;
    logic                  mdio_s2;
    logic                  prev_bit;
    logic                  is_read;
    logic                  addr_match;
    logic [3:0]            cnt;
    logic [15:0]           shift;
    logic [15:0]           rd_shift;
    pbmc_pkg::pbmc_frame_e state;
    logic                  mdc_rise;
    logic                  bit_in;
    logic                  reading;

    // mdc and mdio share the same two-stage delay, so the sample stays aligned
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_s1  <= 1'b0;
            mdc_s2  <= 1'b0;
            mdc_s3  <= 1'b0;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end else begin
            mdc_s1  <= mdc;
            mdc_s2  <= mdc_s1;
            mdc_s3  <= mdc_s2;
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
        end
    end

    assign mdc_rise = mdc_s2 & ~mdc_s3;
    assign bit_in   = mdio_s2;
    assign reading  = addr_match & is_read;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= pbmc_pkg::FR_IDLE;
            prev_bit   <= 1'b0;
            is_read    <= 1'b0;
            addr_match <= 1'b0;
            cnt        <= 4'h0;
            shift      <= 16'h0000;
            rd_shift   <= 16'h0000;
            rd_addr    <= 5'h00;
            mdio_out   <= 1'b0;
            mdio_oe    <= 1'b0;
            wr_req     <= '0;
        end else begin
            wr_req.valid <= 1'b0;
            if (mdc_rise) begin
                prev_bit <= bit_in;
                shift    <= {shift[14:0], bit_in};
                unique case (state)
                    pbmc_pkg::FR_IDLE: begin
                        // a high-to-low step ends preamble or idle, so suppressed preamble works too
                        if (prev_bit && !bit_in) begin
                            state <= pbmc_pkg::FR_START;
                        end
                    end
                    pbmc_pkg::FR_START: begin
                        state <= bit_in ? pbmc_pkg::FR_OP : pbmc_pkg::FR_IDLE;
                        cnt   <= 4'h0;
                    end
                    pbmc_pkg::FR_OP: begin
                        if (cnt == 4'h1) begin
                            cnt <= 4'h0;
                            if ({shift[0], bit_in} == pbmc_pkg::OP_READ || {shift[0], bit_in} == pbmc_pkg::OP_WRITE) begin
                                is_read <= ({shift[0], bit_in} == pbmc_pkg::OP_READ);
                                state   <= pbmc_pkg::FR_PHY;
                            end else begin
                                state <= pbmc_pkg::FR_IDLE;
                            end
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    pbmc_pkg::FR_PHY: begin
                        if (cnt == 4'h4) begin
                            addr_match <= ({shift[3:0], bit_in} == phy_addr);
                            state      <= pbmc_pkg::FR_REG;
                            cnt        <= 4'h0;
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    pbmc_pkg::FR_REG: begin
                        if (cnt == 4'h4) begin
                            rd_addr <= {shift[3:0], bit_in};
                            state   <= pbmc_pkg::FR_TA;
                            cnt     <= 4'h0;
                        end else begin
                            cnt <= cnt + 4'h1;
                        end
                    end
                    pbmc_pkg::FR_TA: begin
                        if (cnt == 4'h0) begin
                            cnt <= 4'h1;
                            if (reading) begin
                                mdio_oe  <= 1'b1;
                                mdio_out <= 1'b0;
                                rd_shift <= rd_data;
                            end
                        end else begin
                            state <= pbmc_pkg::FR_DATA;
                            cnt   <= 4'h0;
                            if (reading) begin
                                mdio_out <= rd_shift[15];
                                rd_shift <= {rd_shift[14:0], 1'b0};
                            end
                        end
                    end
                    pbmc_pkg::FR_DATA: begin
                        if (cnt == 4'hf) begin
                            mdio_oe <= 1'b0;
                            state   <= pbmc_pkg::FR_IDLE;
                            if (addr_match && !is_read) begin
                                wr_req.valid <= 1'b1;
                                wr_req.addr  <= rd_addr;
                                wr_req.data  <= {shift[14:0], bit_in};
                            end
                        end else begin
                            cnt <= cnt + 4'h1;
                            if (reading) begin
                                mdio_out <= rd_shift[15];
                                rd_shift <= {rd_shift[14:0], 1'b0};
                            end
                        end
                    end
                    default: begin
                        state <= pbmc_pkg::FR_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// [testbench/pbmc_chk.sv]
`timescale 1ns/1ps
module pbmc_chk (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       power_down_input_pin_n,
    input wire logic       mac_tx_en,
    input wire logic       an_restart_ack,
    input wire logic       soft_reset_active,
    input wire logic       loopback_en,
    input wire logic [1:0] speed_sel,
    input wire logic       full_duplex,
    input wire logic       an_enable,
    input wire logic       an_restart_req,
    input wire logic       power_down,
    input wire logic       isolate_en,
    input wire logic       mac_col
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_col_on; $rose(mac_col) |-> $past(mac_tx_en, 3); endproperty
    a_col_on: assert property (p_col_on) else $error("collision without transmit enable");
    property p_col_off; $fell(mac_tx_en) |-> ##[0:4] !mac_col; endproperty
    a_col_off: assert property (p_col_off) else $error("collision held too long");
    property p_pin; !power_down_input_pin_n [*6] |-> power_down; endproperty
    a_pin: assert property (p_pin) else $error("pin did not power down");
    property p_rr_an; $rose(an_restart_req) |-> an_enable; endproperty
    a_rr_an: assert property (p_rr_an) else $error("restart with negotiation off");
    property p_rr_hold;
        $fell(an_restart_req) |-> $past(an_restart_ack, 2) || soft_reset_active || $past(soft_reset_active);
    endproperty
    a_rr_hold: assert property (p_rr_hold) else $error("restart cleared without ack");
    property p_no_rsvd; speed_sel != pbmc_pkg::SPEED_RSVD; endproperty
    a_no_rsvd: assert property (p_no_rsvd) else $error("reserved speed code");
    property p_an_hold;
        an_enable && $past(an_enable) && !soft_reset_active |-> $stable(speed_sel) && $stable(full_duplex);
    endproperty
    a_an_hold: assert property (p_an_hold) else $error("manual speed moved in negotiation");
    property p_sr_len; $rose(soft_reset_active) |-> soft_reset_active [*8] ##[1:10] !soft_reset_active; endproperty
    a_sr_len: assert property (p_sr_len) else $error("soft reset length wrong");
    property p_sr_dflt;
        $fell(soft_reset_active) |-> speed_sel == pbmc_pkg::SPEED_1000 && !loopback_en && !isolate_en
            && !an_restart_req && !mac_col;
    endproperty
    a_sr_dflt: assert property (p_sr_dflt) else $error("soft reset left non-default");
endmodule
bind pbmc_top pbmc_chk i_chk (.core_clk(core_clk), .rst_n(rst_n), .power_down_input_pin_n(power_down_input_pin_n),
    .mac_tx_en(mac_tx_en), .an_restart_ack(an_restart_ack), .soft_reset_active(soft_reset_active),
    .loopback_en(loopback_en), .speed_sel(speed_sel), .full_duplex(full_duplex), .an_enable(an_enable),
    .an_restart_req(an_restart_req), .power_down(power_down), .isolate_en(isolate_en), .mac_col(mac_col));

// [testbench/pbmc_sme_model.sv]
`timescale 1ns/1ps
module pbmc_sme_model (
    output logic     mdc,
    output logic     m_out,
    output logic     m_oe,
    input wire logic mdio_wire
);
    // mdc stands low between frames; released line falls back to the pull-up
    initial begin
        mdc = 1'b0;
        m_out = 1'b1;
        m_oe = 1'b0;
    end
    task automatic bit_cycle(input logic drv, input logic b, output logic s);
        m_oe = drv;
        m_out = b;
        #400;
        mdc = 1'b1;
        s = mdio_wire;
        #400;
        mdc = 1'b0;
    endtask
    // short preamble keeps frames cheap; device does not count it
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [17:0] hdr;
        logic        s;
        logic        wr;
        hdr = {4'hf, 2'h1, op, pa, ra};
        // bad opcodes still drive data, so a dropped frame carries a real payload
        wr = (op != pbmc_pkg::OP_READ);
        rd = 16'h0000;
        for (int i = 17; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
        bit_cycle(wr, 1'b1, s);
        bit_cycle(wr, 1'b0, s);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(wr, wd[i], s);
            rd[i] = s;
        end
        m_oe = 1'b0;
        // one idle bit, so the release never meets the next frame's drive in one step
        #800;
    endtask
endmodule

// [testbench/tb_phy_basic_mode_control.sv]
`timescale 1ns/1ps
module tb_phy_basic_mode_control;
    localparam logic [4:0] PA = 5'h09;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        strap_an = 1'b1;
    logic        strap_fd = 1'b0;
    logic        pin_n = 1'b1;
    logic        tx_en = 1'b0;
    logic        ack = 1'b0;
    logic        mdc, m_out, m_oe, mdio_out, mdio_oe, mdio_wire;
    logic        sra, lb, fd, an, rr, pd, iso, col;
    logic [1:0]  spd;
    logic [9:0]  outs;
    logic [15:0] model, w, d;
    logic [31:0] seed = 32'h0000_7fa3;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cyc = 0;
    always #50 core_clk = ~core_clk;
    assign mdio_wire = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);
    assign outs = {sra, lb, spd, fd, an, rr, pd, iso, col};
    pbmc_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .phy_addr_strap(PA), .strap_an_enable(strap_an), .strap_full_duplex(strap_fd),
        .power_down_input_pin_n(pin_n), .mac_tx_en(tx_en), .an_restart_ack(ack), .soft_reset_active(sra),
        .loopback_en(lb), .speed_sel(spd), .full_duplex(fd), .an_enable(an), .an_restart_req(rr),
        .power_down(pd), .isolate_en(iso), .mac_col(col));
    pbmc_sme_model i_sme (.mdc(mdc), .m_out(m_out), .m_oe(m_oe), .mdio_wire(mdio_wire));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] nxt(input logic [15:0] old, input logic [15:0] v);
        logic [15:0] n;
        n = v & 16'h7dc0;
        n[9] = old[9] | (v[9] & v[12]);
        if (v[6] && v[13]) begin
            n[6] = old[6];
            n[13] = old[13];
        end
        return n;
    endfunction
    function automatic logic [9:0] exp_outs(input logic [15:0] r, input logic c);
        return {r[15], r[14], r[6], r[13], r[8], r[12], r[9], r[11], r[10], c};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: register %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [9:0] exp);
        n_checks++;
        if (outs !== exp) begin
            miscompares++;
            $display("wrong value at %0t: outputs %h expected %h", $time, outs, exp);
        end
    endtask
    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] v);
        i_sme.frame(pbmc_pkg::OP_WRITE, pa, ra, v, d);
        repeat (8) @(negedge core_clk);
    endtask
    task automatic rdchk(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
        i_sme.frame(pbmc_pkg::OP_READ, pa, ra, 16'h0000, d);
        chk_reg(d, exp);
    endtask
    task automatic upd(input logic [15:0] v);
        wr(PA, pbmc_pkg::REG_BASIC_MODE_CONTROL, v);
        model = nxt(model, v);
        chk_out(exp_outs(model, 1'b0));
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(negedge core_clk);
        chk_out(10'h080);
        rst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        model = 16'h1040;
        chk_out(exp_outs(model, 1'b0));
        rdchk(PA, 5'h00, model);
        $display("test reset done");
        wr(PA ^ 5'h01, 5'h00, 16'h4000);
        rdchk(PA ^ 5'h01, 5'h00, 16'hffff);
        wr(PA, 5'h01, 16'h4000);
        rdchk(PA, 5'h01, pbmc_pkg::UNMAPPED_READ);
        chk_out(exp_outs(model, 1'b0));
        i_sme.frame(2'h0, PA, 5'h00, 16'h4000, d);
        repeat (8) @(negedge core_clk);
        chk_out(exp_outs(model, 1'b0));
        $display("test address done");
        upd(16'h1240);
        upd(16'h1040);
        rdchk(PA, 5'h00, model);
        @(negedge core_clk) ack = 1'b1;
        @(negedge core_clk) ack = 1'b0;
        repeat (3) @(negedge core_clk);
        model[9] = 1'b0;
        chk_out(exp_outs(model, 1'b0));
        upd(16'h0240);
        $display("test restart done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            w = (i == 0) ? 16'h207f : (i == 1) ? 16'h2000 : (i == 2) ? 16'h0d00 : seed[15:0] & 16'h6dff;
            upd(w);
            rdchk(PA, 5'h00, model);
        end
        upd(16'h4040);
        repeat (5000) @(negedge core_clk); // receive path may stay dead this long
        $display("test fields done");
        pin_n = 1'b0;
        repeat (6) @(negedge core_clk);
        model[11] = 1'b1;
        chk_out(exp_outs(model, 1'b0));
        wr(PA, 5'h00, model & 16'hf7ff);
        rdchk(PA, 5'h00, model);
        pin_n = 1'b1;
        upd(model & 16'hf7ff);
        $display("test pin done");
        upd(model | 16'h0080);
        tx_en = 1'b1;
        repeat (5) @(negedge core_clk);
        chk_out(exp_outs(model, 1'b1));
        tx_en = 1'b0;
        repeat (5) @(negedge core_clk);
        chk_out(exp_outs(model, 1'b0));
        $display("test collision done");
        strap_an = 1'b0;
        strap_fd = 1'b1;
        i_sme.frame(pbmc_pkg::OP_WRITE, PA, 5'h00, 16'hc000, d);
        for (int k = 0; k < 30 && sra !== 1'b1; k++) @(negedge core_clk);
        chk_reg({15'h0000, sra}, 16'h0001);
        for (int k = 0; k < 40 && sra !== 1'b0; k++) @(negedge core_clk);
        chk_reg({15'h0000, sra}, 16'h0000);
        repeat (4) @(negedge core_clk);
        model = 16'h0140;
        chk_out(exp_outs(model, 1'b0));
        rdchk(PA, 5'h00, model);
        $display("test soft reset done");
        report_and_stop();
    end
endmodule
